// *** hdl/downconverter_mode_control.sv ***
// Mode, decimation and input routing logic of the second downconverter.
`timescale 1ns/1ps
module downconverter_mode_control
  import downconverter_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [REG_W-1:0] reg_rdata_o,
  // Converter samples.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [SAMPLE_W-1:0] chan_a_i,
  input wire logic [SAMPLE_W-1:0] chan_b_i,
  // Samples towards the output framer.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [SAMPLE_W-1:0] out_i_o,
  output logic [SAMPLE_W-1:0] out_q_o,
  output logic out_q_valid_o,
  // Decoded configuration.
  output logic [STAGE_N-1:0] stage_en_o,
  output logic [RATIO_W-1:0] dec_ratio_o,
  output logic dec_ok_o
);

  state_s st_reg;
  state_s st_next;
  word_s head;

  // Maps the two decimation fields onto a stage cascade and ratio.
  function automatic dec_cfg_s dec_lookup(input logic [2:0] code,
                                          input logic [3:0] ext,
                                          input logic c2r);
    dec_cfg_s c;
    logic halve;
    c = '0;
    c.ok = 1'b1;
    halve = 1'b1;
    unique case (code)
      DEC_HB12: begin
        c.stages = 7'h03;
        c.ratio = 6'h04;
      end
      DEC_HB123: begin
        c.stages = 7'h07;
        c.ratio = 6'h08;
      end
      DEC_HB1234: begin
        c.stages = 7'h0F;
        c.ratio = 6'h10;
      end
      DEC_HB1: begin
        c.stages = 7'h01;
        c.ratio = 6'h02;
      end
      DEC_HB1_TB2: begin
        c.stages = 7'h21;
        c.ratio = 6'h06;
      end
      DEC_HB12_TB2: begin
        c.stages = 7'h23;
        c.ratio = 6'h0C;
      end
      DEC_HB123_TB2: begin
        c.stages = 7'h27;
        c.ratio = 6'h18;
      end
      DEC_EXTENDED: begin
        // The extended field only matters on this code.
        unique case (ext)
          EXT_HB1234_TB2: begin
            c.stages = 7'h2F;
            c.ratio = 6'h30;
          end
          EXT_HB1_FB: begin
            c.stages = 7'h41;
            c.ratio = 6'h0A;
          end
          EXT_HB12_FB: begin
            c.stages = 7'h43;
            c.ratio = 6'h14;
          end
          EXT_HB123_FB: begin
            c.stages = 7'h47;
            c.ratio = 6'h28;
          end
          EXT_TB1: begin
            c.stages = 7'h10;
            c.ratio = 6'h03;
            halve = 1'b0;
          end
          EXT_TB1_FB: begin
            c.stages = 7'h50;
            c.ratio = 6'h0F;
            halve = 1'b0;
          end
          EXT_TB1_FB_HB2: begin
            c.stages = 7'h52;
            c.ratio = 6'h1E;
            halve = 1'b0;
          end
          default: c.ok = 1'b0;
        endcase
      end
    endcase
    // Real output halves the ratio; third-band one cannot do that.
    if (c2r) begin
      if (halve) begin
        c.ratio = c.ratio >> 1;
      end else begin
        c.ok = 1'b0;
      end
    end
    return c;
  endfunction

  // Multiplies by two with saturation.
  function automatic logic [SAMPLE_W-1:0] times_two(
      input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] r;
    r = {s[SAMPLE_W-2:0], 1'b0};
    if (s[SAMPLE_W-1] != s[SAMPLE_W-2]) begin
      r = {s[SAMPLE_W-1], {(SAMPLE_W-1){~s[SAMPLE_W-1]}}};
    end
    return r;
  endfunction

  // Rotates a complex sample by a quarter turn per phase step.
  function automatic word_s rotate(input word_s w, input logic [1:0] ph);
    word_s r;
    r = w;
    unique case (ph)
      2'h0: r = w;
      2'h1: begin
        r.i = w.q;
        r.q = -w.i;
      end
      2'h2: begin
        r.i = -w.i;
        r.q = -w.q;
      end
      2'h3: begin
        r.i = -w.q;
        r.q = w.i;
      end
    endcase
    return r;
  endfunction

  assign head = word_s'(st_reg.fifo[0]);

  // Next-state logic: registers, mixing, decimation and the buffer.
  always_comb begin
    word_s w;
    logic accept;
    logic pop;
    logic push;
    logic cfg_write;
    logic [1:0] cnt;
    if_mode_e mode;
    st_next = st_reg;
    w = '0;
    push = 1'b0;
    cfg_write = 1'b0;
    cnt = st_reg.count;
    mode = if_mode_e'(st_reg.ctrl[IF_HI:IF_LO]);
    accept = in_valid_i && st_reg.in_ready;
    pop = st_reg.out_valid && out_ready_i;

    // Register writes; reserved input-select bits stay zero.
    if (reg_wr_i && reg_addr_i == CTRL_ADDR) begin
      st_next.ctrl = reg_wdata_i;
      cfg_write = 1'b1;
    end
    if (reg_wr_i && reg_addr_i == INSEL_ADDR) begin
      st_next.ext_dec = reg_wdata_i[EXT_HI:EXT_LO];
      st_next.q_sel = reg_wdata_i[Q_SEL_BIT];
      st_next.i_sel = reg_wdata_i[I_SEL_BIT];
      cfg_write = 1'b1;
    end

    // Register reads; unmapped addresses return zero.
    if (reg_rd_i) begin
      st_next.rdata = '0;
      if (reg_addr_i == CTRL_ADDR) begin
        st_next.rdata = st_reg.ctrl;
      end else if (reg_addr_i == INSEL_ADDR) begin
        st_next.rdata = {st_reg.ext_dec, 1'b0, st_reg.q_sel, 1'b0,
                         st_reg.i_sel};
      end
    end

    // Channel routing: a real mixer feeds Q from I's channel.
    w.i = st_reg.i_sel ? chan_b_i : chan_a_i;
    if (st_reg.ctrl[MIX_BIT]) begin
      w.q = st_reg.q_sel ? chan_b_i : chan_a_i;
    end else begin
      w.q = w.i;
    end
    w.q_valid = 1'b1;

    // Mixing according to the IF mode.
    unique case (mode)
      IF_VARIABLE, IF_ZERO: w = w;
      IF_QUARTER: w = rotate(w, st_reg.mix_phase);
      IF_TEST: begin
        w.i = TEST_WORD;
        w.q = TEST_WORD;
      end
    endcase

    // Optional 6 dB gain.
    if (st_reg.ctrl[GAIN_BIT]) begin
      w.i = times_two(w.i);
      w.q = times_two(w.q);
    end

    // Complex to real: extra quarter-rate mix, I only.
    if (st_reg.ctrl[C2R_BIT]) begin
      w = rotate(w, st_reg.c2r_phase);
      w.q = '0;
      w.q_valid = 1'b0;
    end

    // Keep one sample in each decimation period.
    if (accept) begin
      st_next.mix_phase = st_reg.mix_phase + 2'h1;
      push = st_reg.cfg.ok && st_reg.dec_cnt == '0;
      if (st_reg.dec_cnt + 6'h01 >= st_reg.cfg.ratio) begin
        st_next.dec_cnt = '0;
      end else begin
        st_next.dec_cnt = st_reg.dec_cnt + 6'h01;
      end
    end
    if (push) begin
      st_next.c2r_phase = st_reg.c2r_phase + 2'h1;
    end
    if (cfg_write) begin
      st_next.dec_cnt = '0;
    end
    st_next.cfg = dec_lookup(st_next.ctrl[DEC_HI:DEC_LO], st_next.ext_dec,
                             st_next.ctrl[C2R_BIT]);

    // Two-entry buffer; pop shifts the tail word to the head.
    if (pop) begin
      st_next.fifo[0] = st_reg.fifo[1];
      cnt = cnt - 2'h1;
    end
    if (push) begin
      st_next.fifo[cnt[0]] = w;
      cnt = cnt + 2'h1;
    end
    st_next.count = cnt;
    st_next.out_valid = cnt != 2'h0;
    st_next.in_ready = cnt != 2'(FIFO_DEPTH);
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.ext_dec <= EXT_DEC_RESET;
      st_reg.q_sel <= Q_SEL_RESET;
      st_reg.i_sel <= I_SEL_RESET;
      st_reg.in_ready <= 1'b1;
      st_reg.cfg.ok <= 1'b1;
      st_reg.cfg.stages <= 7'h03;
      st_reg.cfg.ratio <= 6'h04;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops.
  assign reg_rdata_o = st_reg.rdata;
  assign in_ready_o = st_reg.in_ready;
  assign out_valid_o = st_reg.out_valid;
  assign out_i_o = head.i;
  assign out_q_o = head.q;
  assign out_q_valid_o = head.q_valid;
  assign stage_en_o = st_reg.cfg.stages;
  assign dec_ratio_o = st_reg.cfg.ratio;
  assign dec_ok_o = st_reg.cfg.ok;

endmodule // downconverter_mode_control

// *** hdl/downconverter_pkg.sv ***
// Package with register map, field layout and types of the downconverter.
package downconverter_pkg;

  // Register addresses and widths.
  localparam int ADDR_W = 16;
  localparam int REG_W = 8;
  localparam logic [15:0] CTRL_ADDR = 16'h0330;
  localparam logic [15:0] INSEL_ADDR = 16'h0331;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] EXT_DEC_RESET = 4'h0;
  localparam logic Q_SEL_RESET = 1'b1;
  localparam logic I_SEL_RESET = 1'b1;

  // Control register field positions.
  localparam int MIX_BIT = 7;
  localparam int GAIN_BIT = 6;
  localparam int IF_HI = 5;
  localparam int IF_LO = 4;
  localparam int C2R_BIT = 3;
  localparam int DEC_HI = 2;
  localparam int DEC_LO = 0;

  // Input select register field positions.
  localparam int EXT_HI = 7;
  localparam int EXT_LO = 4;
  localparam int Q_SEL_BIT = 2;
  localparam int I_SEL_BIT = 0;

  // Primary decimation codes.
  localparam logic [2:0] DEC_HB12 = 3'h0;
  localparam logic [2:0] DEC_HB123 = 3'h1;
  localparam logic [2:0] DEC_HB1234 = 3'h2;
  localparam logic [2:0] DEC_HB1 = 3'h3;
  localparam logic [2:0] DEC_HB1_TB2 = 3'h4;
  localparam logic [2:0] DEC_HB12_TB2 = 3'h5;
  localparam logic [2:0] DEC_HB123_TB2 = 3'h6;
  localparam logic [2:0] DEC_EXTENDED = 3'h7;

  // Extended decimation codes.
  localparam logic [3:0] EXT_HB1234_TB2 = 4'h0;
  localparam logic [3:0] EXT_HB1_FB = 4'h2;
  localparam logic [3:0] EXT_HB12_FB = 4'h3;
  localparam logic [3:0] EXT_HB123_FB = 4'h4;
  localparam logic [3:0] EXT_TB1 = 4'h7;
  localparam logic [3:0] EXT_TB1_FB = 4'h8;
  localparam logic [3:0] EXT_TB1_FB_HB2 = 4'h9;

  // Filter stage enable positions.
  localparam int STAGE_N = 7;
  localparam int ST_HB1 = 0;
  localparam int ST_HB2 = 1;
  localparam int ST_HB3 = 2;
  localparam int ST_HB4 = 3;
  localparam int ST_TB1 = 4;
  localparam int ST_TB2 = 5;
  localparam int ST_FB = 6;

  // Datapath sizes.
  localparam int SAMPLE_W = 16;
  localparam int RATIO_W = 6;
  localparam int FIFO_DEPTH = 2;
  localparam logic [15:0] TEST_WORD = 16'h5A5A;

  // Intermediate frequency modes.
  typedef enum logic [1:0] {
    IF_VARIABLE,
    IF_ZERO,
    IF_QUARTER,
    IF_TEST
  } if_mode_e;

  // One complex word with its Q qualifier.
  typedef struct packed {
    logic q_valid;
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } word_s;

  // Decoded filter cascade.
  typedef struct packed {
    logic ok;
    logic [STAGE_N-1:0] stages;
    logic [RATIO_W-1:0] ratio;
  } dec_cfg_s;

  // Whole state of the block.
  typedef struct packed {
    logic [REG_W-1:0] ctrl;
    logic [3:0] ext_dec;
    logic q_sel;
    logic i_sel;
    logic [REG_W-1:0] rdata;
    logic [RATIO_W-1:0] dec_cnt;
    logic [1:0] mix_phase;
    logic [1:0] c2r_phase;
    logic [FIFO_DEPTH-1:0][$bits(word_s)-1:0] fifo;
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
    dec_cfg_s cfg;
  } state_s;

endpackage

// *** verification/converter_partner.sv ***
// Model of the converter cores and the output framer.
`timescale 1ns/1ps
module converter_partner (
  // Clock and test control.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic slow_i,
  // Converter side.
  input wire logic in_ready_i,
  output logic in_valid_o,
  output logic [15:0] chan_a_o,
  output logic [15:0] chan_b_o,
  // Framer side.
  output logic out_ready_o
);
  int seed = 3;
  logic tk;
  // Idle state at time zero.
  initial begin
    in_valid_o = 0;
    chan_a_o = 0;
    chan_b_o = 0;
    out_ready_o = 1;
  end
  // A sample holds until taken; idle data changes every cycle.
  always @(posedge clk_i) begin
    tk = in_valid_o && in_ready_i;
    #1;
    if (tk || !in_valid_o) begin
      in_valid_o = go_i && ($random(seed) & 3) != 0;
      chan_a_o = 16'($random(seed));
      chan_b_o = 16'($random(seed));
    end
    out_ready_o = !slow_i || ($random(seed) & 1) != 0;
  end
endmodule // converter_partner

// *** verification/dc_checker_assertions.sv ***
// Port checker for the downconverter mode control.
`timescale 1ns/1ps
module dc_checker
  import downconverter_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [REG_W-1:0] reg_rdata_o,
  // Output stream and configuration.
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [SAMPLE_W-1:0] out_i_o,
  input wire logic [SAMPLE_W-1:0] out_q_o,
  input wire logic out_q_valid_o,
  input wire logic [RATIO_W-1:0] dec_ratio_o,
  input wire logic dec_ok_o
);
  logic wc;
  logic rc;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Control register accesses.
  assign wc = reg_wr_i && reg_addr_i == CTRL_ADDR;
  assign rc = reg_rd_i && reg_addr_i == CTRL_ADDR;
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
    && $stable({out_i_o, out_q_o, out_q_valid_o})) else $error("word moved");
  a_q_zero: assert property (
    out_valid_o && !out_q_valid_o |-> out_q_o == '0) else $error("q not 0");
  a_rd_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_unmapped_read: assert property (reg_rd_i && reg_addr_i != CTRL_ADDR
    && reg_addr_i != INSEL_ADDR |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not 0");
  a_ctrl_back: assert property (
    wc && !rc ##1 rc && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("control readback");
  a_sel_reserved: assert property (
    reg_rd_i && reg_addr_i == INSEL_ADDR |=> !reg_rdata_o[3] && !reg_rdata_o[1])
    else $error("reserved bit set");
  a_single_stage: assert property (
    wc && reg_wdata_i[3:0] == 4'hB |=> dec_ratio_o == 6'h01 && dec_ok_o)
    else $error("ratio not 1");
  a_ext_ignored: assert property (
    wc && reg_wdata_i[3:0] == 4'h0 |=> dec_ratio_o == 6'h04 && dec_ok_o)
    else $error("ratio not 4");
endmodule // dc_checker

// *** verification/downconverter_mode_control_tb.sv ***
// Self-checking bench for the downconverter mode control.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module downconverter_mode_control_tb;
  import downconverter_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic go = 0;
  logic slow = 0;
  logic [15:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0;
  logic in_valid_i, out_ready_i, in_ready_o, out_valid_o, out_q_valid_o;
  logic dec_ok_o;
  logic [15:0] chan_a_i, chan_b_i, out_i_o, out_q_o;
  logic [7:0] reg_rdata_o;
  logic [5:0] dec_ratio_o;
  logic [6:0] stage_en_o;
  logic [7:0] ctl = 8'h00;
  logic [7:0] sel = 8'h05;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int ph = 0;
  int rat = 4;
  int ok = 1;
  int stg = 3;
  int mph = 0;
  int cph = 0;
  always #20 clk_i = ~clk_i;
  downconverter_mode_control downconverter_mode_control_i (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .in_valid_i, .in_ready_o, .chan_a_i, .chan_b_i, .out_valid_o,
    .out_ready_i, .out_i_o, .out_q_o, .out_q_valid_o, .stage_en_o,
    .dec_ratio_o, .dec_ok_o);
  converter_partner converter_partner_i (.clk_i, .go_i(go), .slow_i(slow),
    .in_ready_i(in_ready_o), .in_valid_o(in_valid_i), .chan_a_o(chan_a_i),
    .chan_b_o(chan_b_i), .out_ready_o(out_ready_i));
  // Doubling with saturation.
  function automatic logic [15:0] g2(logic [15:0] s);
    if (!ctl[6]) return s;
    if (s[15] != s[14]) return s[15] ? 16'h8000 : 16'h7FFF;
    return {s[14:0], 1'b0};
  endfunction
  // Quarter turn per step: I + jQ multiplied by -j.
  function automatic logic [31:0] rot(logic [15:0] i, logic [15:0] q, int p);
    case (p % 4)
      1: return {q, -i};
      2: return {-i, -q};
      3: return {-q, i};
      default: return {i, q};
    endcase
  endfunction
  // Expected word: Q valid flag, I, Q; mp and cp are the two mix phases.
  function automatic logic [32:0] word(logic [15:0] a, logic [15:0] b,
                                       int mp, int cp);
    logic [15:0] i;
    logic [15:0] q;
    i = sel[0] ? b : a;
    q = ctl[7] ? (sel[2] ? b : a) : i;
    if (ctl[5:4] == 2'b10) {i, q} = rot(i, q, mp);
    if (ctl[5:4] == 2'b11) begin
      i = TEST_WORD;
      q = TEST_WORD;
    end
    i = g2(i);
    q = g2(q);
    if (ctl[3]) {i, q} = rot(i, q, cp);
    return {~ctl[3], i, ctl[3] ? 16'h0000 : q};
  endfunction
  // Ratio and support from the two decimation fields.
  task automatic decode;
    int c = ctl[3];
    int pr[8] = '{4, 8, 16, 2, 6, 12, 24, 0};
    int er[16] = '{48, 0, 10, 20, 40, 0, 0, 3, 15, 30, 0, 0, 0, 0, 0, 0};
    int ps[8] = '{3, 7, 15, 1, 33, 35, 39, 0};
    int es[16] = '{47, 0, 65, 67, 71, 0, 0, 16, 80, 82, 0, 0, 0, 0, 0, 0};
    ok = 1;
    rat = pr[ctl[2:0]] >> c;
    stg = ps[ctl[2:0]];
    if (ctl[2:0] == 3'h7) begin
      rat = er[sel[7:4]] >> c;
      stg = es[sel[7:4]];
      ok = er[sel[7:4]] != 0 && !(c == 1 && sel[7:4] inside {7, 8, 9});
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(posedge clk_i);
    #1;
    reg_wr_i = 0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] x);
    reg_addr_i = a;
    reg_rd_i = 1;
    @(posedge clk_i);
    #1;
    reg_rd_i = 0;
    `CHK(reg_rdata_o, x)
    // One idle edge so that a following read raises its strobe anew.
    @(posedge clk_i);
    #1;
  endtask
  task automatic drain;
    int n = 0;
    while ((in_valid_i || out_valid_o) && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(exp_q.size(), 0)
  endtask
  task complete_run;
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reference model of keeping, routing and output order.
  always @(posedge clk_i) begin
    cyc++;
    if (reg_wr_i) ph = 0;
    if (in_valid_i && in_ready_o) begin
      if (ok != 0 && ph == 0) begin
        exp_q.push_back(word(chan_a_i, chan_b_i, mph, cph));
        cph++;
      end
      if (ok != 0) ph = (ph + 1) % rat;
      mph++;
    end
    if (out_valid_o && out_ready_i) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h0;
      `CHK(out_q_valid_o, e[32])
      `CHK(out_i_o, e[31:16])
      `CHK(out_q_o, e[15:0])
    end
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  // Reset, register reset values, then every decimation setting.
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1;
    `CHK(dec_ratio_o, 6'h04)
    `CHK(stage_en_o, 7'h03)
    rd(CTRL_ADDR, 8'h00);
    rd(INSEL_ADDR, 8'h05);
    rd(16'h0332, 8'h00);
    for (int k = 0; k < 46; k++) begin
      drain;
      ctl[7:3] = {k[1] ^ k[2], k[2], 2'((k + k / 4) % 4), k[0]};
      ctl[2:0] = k < 16 ? 3'(k >> 1) : 3'h7;
      sel = {k < 16 ? 4'(k) : 4'((k - 16) >> 1), 1'b0, k[1], 1'b0, k[3]};
      wr(CTRL_ADDR, ctl);
      rd(CTRL_ADDR, ctl);
      wr(INSEL_ADDR, sel);
      rd(INSEL_ADDR, sel);
      decode;
      `CHK(dec_ok_o, ok[0])
      if (ok != 0) `CHK(dec_ratio_o, 6'(rat))
      if (ok != 0) `CHK(stage_en_o, 7'(stg))
      slow = k[2];
      go = 1;
      repeat (60) @(posedge clk_i);
      #1;
      go = 0;
    end
    drain;
    complete_run;
  end
endmodule // downconverter_mode_control_tb
bind downconverter_mode_control dc_checker dc_checker_i (.clk_i, .rst_n_i,
  .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .out_valid_o, .out_ready_i, .out_i_o, .out_q_o, .out_q_valid_o,
  .dec_ratio_o, .dec_ok_o);
